//--- src/cmbh_top.sv
// Purpose: transmit-slot flags, receive-slot search, filtering and remote answers
// Assumes: protocol engine outside reports arbitration, sends and frames as pulses
// Notes:
// Notes on behaviour
// [R1] write 1 to bit 1 requests removal
// [R2] removal flag held while still unresolved
// [R3] cleared on win (done) or withdrawal (silent)
// [R4] send plus removal together means one-shot; code sets one-shot only if send was clear
// [R5] one-shot success clears both flags
// [R6] one-shot loss clears both, raises fail
// [R7] thirty-two receive slots, own filters each
// [R8] accepted frame sets message-present flag
// [R9] software clears present before slot reuse
// [R10] ascending search over enabled matching slots
// [R11] empty slot stores, stored irq if enabled
// [R12] full unchained slot drops, raises overflow
// [R13] full chained slot continues; none means overflow
// [R14] remote frame with answer enabled triggers reply
// [R15] pending flag until sent, disabled, cancelled
// [R16] sent flag after reply, write 1 clears
// [R17] remote irq from present/answered and enable
// [R18] extended id [31:3], standard id [31:21]
// [R19] mask 0 compares, mask 1 ignores
// [R20] chained slots share filters, last unchained
// [R21] send flag bit 0, done event bit 11
// [R22] unmatched frame dropped without events
`timescale 1ns/100ps
`default_nettype none
`include "cmbh_consts.svh"
module cmbh_top #(
   parameter int N_TX = 32,
   parameter int N_RX = 32,
   parameter int IW = 5
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic [N_TX-1:0] TX_SEND_REQUEST,
   output logic [N_TX-1:0] TX_ONE_SHOT_SEND,
   input wire logic [IW-1:0] TXE_SLOT,
   input wire logic TXE_WON,
   input wire logic TXE_DONE,
   input wire logic TXE_LOST,
   input wire logic RXF_VALID,
   input wire logic RXF_EXT,
   input wire logic RXF_RTR,
   input wire logic [28:0] RXF_ID,
   input wire logic [63:0] RXF_DATA,
   output logic [N_RX-1:0] RA_PENDING,
   input wire logic RA_SENT,
   input wire logic [IW-1:0] RA_SLOT,
   input wire logic [IW-1:0] RD_SLOT,
   output logic [31:0] RD_IDENT,
   output logic [63:0] RD_DATA,
   output logic [15:0] EVT,
   output logic REMOTE_IRQ
);
   // ==========================================================
   // state
   typedef cmbh_pkg::cmbh_rx_t [N_RX-1:0] cmbh_rxa_t;
   typedef struct packed {
      cmbh_pkg::cmbh_tx_t [N_TX-1:0] tx;
      cmbh_rxa_t rx; // [R7]
      logic act;
      logic [IW-1:0] act_slot;
      logic [31:0] rdata;
      logic [31:0] rd_ident;
      logic [63:0] rd_data;
      logic [15:0] evt;
   } cmbh_st_t;
   typedef struct packed {
      cmbh_pkg::cmbh_kind_t kind;
      logic [IW-1:0] idx;
   } cmbh_srch_t;

   cmbh_st_t st_reg;
   cmbh_st_t st_next;
   cmbh_srch_t srch;
   logic [31:0] fid;
   logic [15:0] fdat;
   logic [N_TX-1:0] withdraw;
   logic [N_RX-1:0] irq_src;
   logic [IW-1:0] rslot;
   logic [2:0] rfield;

   assign rslot = REG_ADDR[5+IW-1:5];
   assign rfield = REG_ADDR[4:2];

   // frame identifier word as stored and as filtered
   assign fid = RXF_EXT ? {RXF_ID, 1'b1, RXF_RTR, 1'b0} : // [R18]
      {RXF_ID[10:0], 18'h00000, 1'b0, RXF_RTR, 1'b0};
   assign fdat = {RXF_DATA[7:0], RXF_DATA[15:8]};

   // ==========================================================
   // receive search: lowest enabled matching slot decides, unless it is full and chained
   function automatic cmbh_srch_t search(input cmbh_rxa_t rx, input logic vld,
         input logic [31:0] id, input logic [15:0] dat, input logic rtr);
      cmbh_srch_t r;
      logic stop;
      logic full;
      logic hit;
      r.kind = cmbh_pkg::SR_NONE;
      r.idx = '0;
      stop = 1'b0;
      full = 1'b0;
      for (int i = 0; i < N_RX; i++) begin
         hit = rx[i].c.on && (((id ^ rx[i].code_id) & ~rx[i].mask_id) == 32'h00000000) &&
            (((dat ^ rx[i].code_dat) & ~rx[i].mask_dat) == 16'h0000); // [R19] [R10]
         if (vld && !stop && hit) begin
            if (rtr && rx[i].c.remote_on) begin
               r.kind = cmbh_pkg::SR_REMOTE; // [R14]
               r.idx = IW'(i);
               stop = 1'b1;
            end else if (!rx[i].c.present) begin
               r.kind = cmbh_pkg::SR_STORE; // [R11]
               r.idx = IW'(i);
               stop = 1'b1;
            end else if (!rx[i].c.chain) begin
               r.kind = cmbh_pkg::SR_OVER; // [R12]
               r.idx = IW'(i);
               stop = 1'b1;
            end else begin
               full = 1'b1; // [R13]
            end
         end
      end
      // chained full slots with no free follower lose the frame
      if (!stop && full) begin
         r.kind = cmbh_pkg::SR_OVER; // [R13]
      end
      return r; // no hit at all stays SR_NONE [R22]
   endfunction

   assign srch = search(st_reg.rx, RXF_VALID, fid, fdat, RXF_RTR);

   // ==========================================================
   // per-slot withdrawal and remote irq sources
   genvar g;
   generate
      for (g = 0; g < N_TX; g++) begin : g_tx
         // a slot on the bus cannot be pulled; one-shot waits for its outcome
         assign withdraw[g] = st_reg.tx[g].removal && !st_reg.tx[g].one_shot &&
            !(st_reg.act && st_reg.act_slot == IW'(g)) &&
            !(TXE_WON && TXE_SLOT == IW'(g)); // [R1] [R3]
         assign TX_SEND_REQUEST[g] = st_reg.tx[g].send;
         assign TX_ONE_SHOT_SEND[g] = st_reg.tx[g].one_shot;
      end
      for (g = 0; g < N_RX; g++) begin : g_rx
         assign irq_src[g] = (st_reg.rx[g].c.present || st_reg.rx[g].c.sent) &&
            st_reg.rx[g].c.irq_on && st_reg.rx[g].c.remote_on; // [R17]
         assign RA_PENDING[g] = st_reg.rx[g].c.pending;
      end
   endgenerate

   // ==========================================================
   // next state: host writes first, hardware sets after, so sets win; a slot left disabled still drops pending
   always_comb begin
      st_next = st_reg;
      st_next.evt = 16'h0000;
      st_next.rdata = 32'h00000000;
      st_next.rd_ident = st_reg.rx[RD_SLOT].ident;
      st_next.rd_data = st_reg.rx[RD_SLOT].data;
      // host register writes
      if (REG_WR && REG_ADDR[11:10] == `CMBH_REG_TX && rfield == `CMBH_F_CTRL) begin
         if (REG_WDATA[`CMBH_TX_SEND] && REG_WDATA[`CMBH_TX_REMOVE] &&
               !st_reg.tx[rslot].send) begin
            st_next.tx[rslot].one_shot = 1'b1; // [R4]
         end
         if (REG_WDATA[`CMBH_TX_SEND]) begin
            st_next.tx[rslot].send = 1'b1; // [R21]
         end
         if (REG_WDATA[`CMBH_TX_REMOVE]) begin
            st_next.tx[rslot].removal = 1'b1; // [R1]
         end
      end
      if (REG_WR && REG_ADDR[11:10] == `CMBH_REG_RX) begin
         case (rfield)
            `CMBH_F_CTRL: begin
               st_next.rx[rslot].c.on = REG_WDATA[`CMBH_RX_ON];
               st_next.rx[rslot].c.irq_on = REG_WDATA[`CMBH_RX_IRQ_ON];
               st_next.rx[rslot].c.chain = REG_WDATA[`CMBH_RX_CHAIN];
               st_next.rx[rslot].c.remote_on = REG_WDATA[`CMBH_RX_REMOTE_ON];
               if (REG_WDATA[`CMBH_RX_PRESENT]) begin
                  st_next.rx[rslot].c.present = 1'b0; // [R9]
               end
               if (REG_WDATA[`CMBH_RX_SENT]) begin
                  st_next.rx[rslot].c.sent = 1'b0; // [R16]
               end
               if (REG_WDATA[`CMBH_RX_CANCEL]) begin
                  st_next.rx[rslot].c.pending = 1'b0; // [R15]
               end
            end
            `CMBH_F_IDENT: st_next.rx[rslot].ident = REG_WDATA;
            `CMBH_F_DATA_LO: st_next.rx[rslot].data[31:0] = REG_WDATA;
            `CMBH_F_DATA_HI: st_next.rx[rslot].data[63:32] = REG_WDATA;
            `CMBH_F_MASK_ID: st_next.rx[rslot].mask_id = REG_WDATA;
            `CMBH_F_CODE_ID: st_next.rx[rslot].code_id = REG_WDATA;
            `CMBH_F_FILT_DAT: begin
               st_next.rx[rslot].mask_dat = REG_WDATA[31:16];
               st_next.rx[rslot].code_dat = REG_WDATA[15:0];
            end
            default: begin
            end
         endcase
      end
      // transmit engine outcomes
      if (TXE_WON) begin
         st_next.act = 1'b1;
         st_next.act_slot = TXE_SLOT;
      end
      for (int i = 0; i < N_TX; i++) begin
         if (withdraw[i]) begin
            st_next.tx[i] = '0; // silent withdrawal [R3]
         end
      end
      if (TXE_DONE) begin
         st_next.act = 1'b0;
         st_next.tx[TXE_SLOT] = '0; // [R5] [R21]
         st_next.evt[`CMBH_EVT_TX_DONE] = 1'b1; // [R3] [R21]
      end else if (TXE_LOST) begin
         st_next.act = 1'b0;
         // plain slots stay queued for retry; one-shot never retries
         if (st_reg.tx[TXE_SLOT].one_shot) begin
            st_next.tx[TXE_SLOT] = '0; // [R4] [R6]
            st_next.evt[`CMBH_EVT_ONE_SHOT_FAIL] = 1'b1; // [R6]
         end
      end
      // receive outcomes
      case (srch.kind)
         cmbh_pkg::SR_STORE: begin
            st_next.rx[srch.idx].c.present = 1'b1; // [R8] [R11]
            st_next.rx[srch.idx].ident = fid; // [R18]
            st_next.rx[srch.idx].data = RXF_DATA;
            st_next.evt[`CMBH_EVT_RX_STORED] = st_reg.rx[srch.idx].c.irq_on; // [R11]
         end
         cmbh_pkg::SR_OVER: st_next.evt[`CMBH_EVT_RX_OVERFLOW] = 1'b1; // [R12] [R13]
         cmbh_pkg::SR_REMOTE: st_next.rx[srch.idx].c.pending = 1'b1; // [R14] [R15]
         default: begin
         end
      endcase
      if (RA_SENT) begin
         st_next.rx[RA_SLOT].c.pending = 1'b0; // [R15]
         st_next.rx[RA_SLOT].c.sent = 1'b1; // [R16]
      end
      for (int i = 0; i < N_RX; i++) begin
         if (!st_next.rx[i].c.on) begin
            st_next.rx[i].c.pending = 1'b0; // disabled slot drops reply [R15]
         end
      end
      // register reads answer one cycle later
      if (REG_RD && REG_ADDR[11:10] == `CMBH_REG_TX && rfield == `CMBH_F_CTRL) begin
         st_next.rdata[`CMBH_TX_SEND] = st_reg.tx[rslot].send;
         st_next.rdata[`CMBH_TX_REMOVE] = st_reg.tx[rslot].removal; // [R2]
         st_next.rdata[`CMBH_TX_ONE_SHOT] = st_reg.tx[rslot].one_shot;
      end
      if (REG_RD && REG_ADDR[11:10] == `CMBH_REG_RX) begin
         case (rfield)
            `CMBH_F_CTRL: begin
               st_next.rdata[`CMBH_RX_PRESENT] = st_reg.rx[rslot].c.present;
               st_next.rdata[`CMBH_RX_PENDING] = st_reg.rx[rslot].c.pending;
               st_next.rdata[`CMBH_RX_SENT] = st_reg.rx[rslot].c.sent;
               st_next.rdata[`CMBH_RX_ON] = st_reg.rx[rslot].c.on;
               st_next.rdata[`CMBH_RX_IRQ_ON] = st_reg.rx[rslot].c.irq_on;
               st_next.rdata[`CMBH_RX_CHAIN] = st_reg.rx[rslot].c.chain;
               st_next.rdata[`CMBH_RX_REMOTE_ON] = st_reg.rx[rslot].c.remote_on;
            end
            `CMBH_F_IDENT: st_next.rdata = st_reg.rx[rslot].ident;
            `CMBH_F_DATA_LO: st_next.rdata = st_reg.rx[rslot].data[31:0];
            `CMBH_F_DATA_HI: st_next.rdata = st_reg.rx[rslot].data[63:32];
            `CMBH_F_MASK_ID: st_next.rdata = st_reg.rx[rslot].mask_id;
            `CMBH_F_CODE_ID: st_next.rdata = st_reg.rx[rslot].code_id;
            `CMBH_F_FILT_DAT: st_next.rdata = {st_reg.rx[rslot].mask_dat,
               st_reg.rx[rslot].code_dat};
            default: st_next.rdata = 32'h00000000;
         endcase
      end
   end

   // state register, synchronous reset
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign REG_RDATA = st_reg.rdata;
   assign RD_IDENT = st_reg.rd_ident;
   assign RD_DATA = st_reg.rd_data;
   assign EVT = st_reg.evt;
   assign REMOTE_IRQ = |irq_src; // [R17]

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   sequence s_done;
      TXE_DONE && !REG_WR;
   endsequence
   sequence s_done_seen;
      EVT[`CMBH_EVT_TX_DONE] && !TX_SEND_REQUEST[$past(TXE_SLOT)];
   endsequence
   property p_done_clears;
      s_done |=> s_done_seen;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("done left flags"); // [R5] [R21]

   property p_fail;
      (TXE_LOST && !TXE_DONE && !REG_WR && st_reg.tx[TXE_SLOT].one_shot) |=>
         EVT[`CMBH_EVT_ONE_SHOT_FAIL] && !TX_ONE_SHOT_SEND[$past(TXE_SLOT)];
   endproperty
   a_fail: assert property (p_fail) else $error("one-shot loss not reported"); // [R6]

   property p_keep;
      (st_reg.act && st_reg.tx[st_reg.act_slot].removal && !TXE_DONE && !TXE_LOST) |=>
         st_reg.tx[$past(st_reg.act_slot)].removal;
   endproperty
   a_keep: assert property (p_keep) else $error("removal dropped early"); // [R2]

   property p_withdraw;
      (|withdraw && !TXE_DONE) |=> !EVT[`CMBH_EVT_TX_DONE];
   endproperty
   a_withdraw: assert property (p_withdraw) else $error("withdrawal raised done"); // [R3]

   sequence s_store_hit;
      srch.kind == cmbh_pkg::SR_STORE;
   endsequence
   property p_store;
      s_store_hit |=> st_reg.rx[$past(srch.idx)].c.present &&
         (EVT[`CMBH_EVT_RX_STORED] == $past(st_reg.rx[srch.idx].c.irq_on));
   endproperty
   a_store: assert property (p_store) else $error("frame not stored"); // [R8] [R11]

   property p_over;
      (srch.kind == cmbh_pkg::SR_OVER) |=>
         EVT[`CMBH_EVT_RX_OVERFLOW] && !EVT[`CMBH_EVT_RX_STORED];
   endproperty
   a_over: assert property (p_over) else $error("overflow missing"); // [R12] [R13]

   property p_drop;
      (RXF_VALID && srch.kind == cmbh_pkg::SR_NONE) |=>
         !EVT[`CMBH_EVT_RX_OVERFLOW] && !EVT[`CMBH_EVT_RX_STORED];
   endproperty
   a_drop: assert property (p_drop) else $error("unmatched frame raised event"); // [R22]

   property p_remote;
      (srch.kind == cmbh_pkg::SR_REMOTE && !REG_WR && !RA_SENT) |=>
         RA_PENDING[$past(srch.idx)] && !EVT[`CMBH_EVT_RX_STORED];
   endproperty
   a_remote: assert property (p_remote) else $error("remote frame not answered"); // [R14] [R15]

   property p_sent;
      (RA_SENT && !REG_WR) |=> st_reg.rx[$past(RA_SLOT)].c.sent &&
         !RA_PENDING[$past(RA_SLOT)];
   endproperty
   a_sent: assert property (p_sent) else $error("sent flag not set"); // [R16]
endmodule // cmbh_top
`default_nettype wire

//--- src/cmbh_consts.svh
// Purpose: offsets, field positions and event bits of the message-buffer handler
// Assumes: included by its bare name
// Notes: register word address = region/slot/field taken from REG_ADDR
`ifndef CMBH_CONSTS_SVH
`define CMBH_CONSTS_SVH
// ==========================================================
// address decode
`define CMBH_REG_TX 2'h0
`define CMBH_REG_RX 2'h1
`define CMBH_F_CTRL 3'h0
`define CMBH_F_IDENT 3'h1
`define CMBH_F_DATA_LO 3'h2
`define CMBH_F_DATA_HI 3'h3
`define CMBH_F_MASK_ID 3'h4
`define CMBH_F_CODE_ID 3'h5
`define CMBH_F_FILT_DAT 3'h6
// ==========================================================
// transmit control word bits
`define CMBH_TX_SEND 0
`define CMBH_TX_REMOVE 1
`define CMBH_TX_ONE_SHOT 2
// ==========================================================
// receive control word bits
`define CMBH_RX_PRESENT 0
`define CMBH_RX_PENDING 1
`define CMBH_RX_SENT 2
`define CMBH_RX_CANCEL 3
`define CMBH_RX_ON 4
`define CMBH_RX_IRQ_ON 5
`define CMBH_RX_CHAIN 6
`define CMBH_RX_REMOTE_ON 7
// ==========================================================
// event vector bits
`define CMBH_EVT_TX_DONE 11
`define CMBH_EVT_ONE_SHOT_FAIL 12
`define CMBH_EVT_RX_STORED 13
`define CMBH_EVT_RX_OVERFLOW 14
`endif

//--- src/cmbh_pkg.sv
// Purpose: types of the message-buffer handler
// Assumes: nothing
// Notes: slot arrays are built in the module from its parameters
`default_nettype none
package cmbh_pkg;
   // ==========================================================
   // slot types
   typedef struct packed {
      logic one_shot;
      logic removal;
      logic send;
   } cmbh_tx_t;
   typedef struct packed {
      logic remote_on;
      logic chain;
      logic irq_on;
      logic on;
      logic sent;
      logic pending;
      logic present;
   } cmbh_rxc_t;
   typedef struct packed {
      cmbh_rxc_t c;
      logic [31:0] ident;
      logic [63:0] data;
      logic [31:0] mask_id;
      logic [31:0] code_id;
      logic [15:0] mask_dat;
      logic [15:0] code_dat;
   } cmbh_rx_t;
   typedef enum logic [1:0] {SR_NONE, SR_STORE, SR_OVER, SR_REMOTE} cmbh_kind_t;
endpackage
`default_nettype wire

//--- verification/cmbh_engine_model.sv
// Purpose: protocol-engine stand-in on the far side of the handler
// Assumes: tb calls pulse() for transmit outcomes; replies run on their own
// Notes: released slot lines show the inverse of their last value, except rd_slot, which holds its last one
`timescale 1ns/100ps
`default_nettype none
module cmbh_engine_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reply_en,
   input wire logic [3:0] reply_wait,
   input wire logic [31:0] ra_pending,
   output logic [4:0] txe_slot,
   output logic txe_won,
   output logic txe_done,
   output logic txe_lost,
   output logic ra_sent,
   output logic [4:0] ra_slot,
   output logic [4:0] rd_slot
);
   logic [4:0] first;
   logic [3:0] wait_cnt;
   // ==========================================
   // transmit outcomes
   initial begin
      {txe_won, txe_done, txe_lost} = 3'h0;
      txe_slot = 5'h0;
   end
   // one outcome pulse; a lost frame is never resent here, the slot flags decide
   task automatic pulse(input logic [1:0] kind, input logic [4:0] slot);
      @(posedge clk_sys);
      txe_slot <= slot;
      txe_won <= (kind == 2'h0);
      txe_done <= (kind == 2'h1);
      txe_lost <= (kind == 2'h2);
      @(posedge clk_sys);
      {txe_won, txe_done, txe_lost} <= 3'h0;
      txe_slot <= ~slot;
   endtask
   // ==========================================
   // automatic remote answers
   // lowest pending slot is answered first
   always_comb begin
      first = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (ra_pending[i] === 1'b1) first = i[4:0];
      end
   end
   // answer after reply_wait cycles with the slot content at rd_slot
   always @(posedge clk_sys) begin
      if (!rst_n || !reply_en || ra_sent) begin
         wait_cnt <= 4'h0;
         ra_sent <= 1'b0;
         ra_slot <= ~ra_slot;
      end else if (|ra_pending) begin
         rd_slot <= first;
         if (wait_cnt == reply_wait) begin
            ra_sent <= 1'b1;
            ra_slot <= first;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
   initial begin
      ra_sent = 1'b0;
      ra_slot = 5'h0;
      rd_slot = 5'h0;
   end
endmodule // cmbh_engine_model
`default_nettype wire

//--- verification/tb.sv
// Purpose: self-checking bench of the message-buffer handler
// Assumes: cmbh_top with its default 32 slots on each side
// Notes: event pulses are tallied every cycle so that stray events show up
`timescale 1ns/100ps
`default_nettype none
`include "cmbh_consts.svh"
module tb;
   logic clk_sys, rst_n, reg_wr, reg_rd, rxf_valid, rxf_ext, rxf_rtr, ra_sent, remote_irq;
   logic reply_en, txe_won, txe_done, txe_lost;
   logic [3:0] reply_wait;
   logic [4:0] txe_slot, ra_slot, rd_slot;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, tx_send_request, tx_one_shot_send, ra_pending;
   logic [31:0] rd_ident, seed, mask, code, dword, id_f, r;
   logic [28:0] rxf_id;
   logic [63:0] rxf_data, rd_data;
   logic [15:0] evt, dat;
   int fails, samples_checked, evt_cnt[4], exp_cnt[4];
   cmbh_top cmbh_top_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .TX_SEND_REQUEST(tx_send_request), .TX_ONE_SHOT_SEND(tx_one_shot_send),
      .TXE_SLOT(txe_slot), .TXE_WON(txe_won), .TXE_DONE(txe_done), .TXE_LOST(txe_lost),
      .RXF_VALID(rxf_valid), .RXF_EXT(rxf_ext), .RXF_RTR(rxf_rtr), .RXF_ID(rxf_id),
      .RXF_DATA(rxf_data), .RA_PENDING(ra_pending), .RA_SENT(ra_sent), .RA_SLOT(ra_slot),
      .RD_SLOT(rd_slot), .RD_IDENT(rd_ident), .RD_DATA(rd_data), .EVT(evt),
      .REMOTE_IRQ(remote_irq));
   cmbh_engine_model cmbh_engine_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .reply_en(reply_en), .reply_wait(reply_wait), .ra_pending(ra_pending),
      .txe_slot(txe_slot), .txe_won(txe_won), .txe_done(txe_done), .txe_lost(txe_lost),
      .ra_sent(ra_sent), .ra_slot(ra_slot), .rd_slot(rd_slot));
   // ==========================================
   // clock, event tally, watchdog
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // a one-cycle pulse is counted exactly once, a stuck one many times
   always @(posedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (evt[11 + i] === 1'b1) evt_cnt[i]++;
      end
   end
   // the sequence needs about 400 cycles; 10000 means a hang
   initial begin
      #100000;
      fails++;
      test_done();
   end
   // ==========================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] ident_of(input logic ext, input logic rtr,
         input logic [28:0] id);
      return ext ? {id, 1'b1, rtr, 1'b0} : {id[10:0], 18'h00000, 1'b0, rtr, 1'b0};
   endfunction
   // filter against the slot-0 settings held in mask, code and dword
   function automatic logic hits(input logic [31:0] idw, input logic [15:0] d);
      return (((idw ^ code) & ~mask) == 32'h0) && (((d ^ dword[15:0]) & ~dword[31:16]) == 16'h0);
   endfunction
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] rg, input logic [4:0] s, input logic [2:0] f,
         input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= {rg, s, f, 2'h0};
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~{rg, s, f, 2'h0};
      reg_wdata <= ~d;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] rg, input logic [4:0] s, input logic [2:0] f,
         input logic [31:0] exp, input string what);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= {rg, s, f, 2'h0};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~{rg, s, f, 2'h0};
      #1;
      chk(what, {32'h0, exp}, {32'h0, reg_rdata});
   endtask
   task automatic frame(input logic ext, input logic rtr, input logic [28:0] id,
         input logic [63:0] d);
      @(posedge clk_sys);
      rxf_valid <= 1'b1;
      rxf_ext <= ext;
      rxf_rtr <= rtr;
      rxf_id <= id;
      rxf_data <= d;
      @(posedge clk_sys);
      rxf_valid <= 1'b0;
      rxf_ext <= ~ext;
      rxf_rtr <= ~rtr;
      rxf_id <= ~id;
      rxf_data <= ~d;
      #1;
   endtask
   task automatic eng(input logic [1:0] k, input logic [4:0] s);
      cmbh_engine_model_inst.pulse(k, s);
   endtask
   task automatic evt_chk();
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 4; i++) chk("event count", exp_cnt[i], evt_cnt[i]);
   endtask
   task automatic cfg(input logic [4:0] s, input logic [31:0] ctl, input logic [31:0] idw);
      wr(2'h1, s, `CMBH_F_MASK_ID, 32'h0);
      wr(2'h1, s, `CMBH_F_CODE_ID, idw);
      wr(2'h1, s, `CMBH_F_FILT_DAT, 32'hFFFF0000);
      wr(2'h1, s, `CMBH_F_CTRL, ctl);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      seed = 32'h77BF;
      {reg_wr, reg_rd, rxf_valid, rxf_ext, rxf_rtr, rst_n} = 6'h00;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      rxf_id = 29'h0;
      rxf_data = 64'h0;
      reply_en = 1'b1;
      reply_wait = 4'h0;
      fails = 0;
      samples_checked = 0;
      for (int i = 0; i < 4; i++) {evt_cnt[i], exp_cnt[i]} = 64'h0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(2'h2, 5'h00, 3'h0, 32'h0, "unmapped read");
      // transmit: plain send, withdrawal, removal while on the bus
      wr(2'h0, 5'h02, 3'h0, 32'h1);
      chk("send flag", 1'b1, tx_send_request[2]);
      eng(2'h0, 5'h02);
      eng(2'h1, 5'h02);
      exp_cnt[0]++;
      rd(2'h0, 5'h02, 3'h0, 32'h0, "sent ctrl");
      wr(2'h0, 5'h04, 3'h0, 32'h1);
      wr(2'h0, 5'h04, 3'h0, 32'h2);
      rd(2'h0, 5'h04, 3'h0, 32'h0, "withdrawn ctrl");
      wr(2'h0, 5'h05, 3'h0, 32'h1);
      eng(2'h0, 5'h05);
      wr(2'h0, 5'h05, 3'h0, 32'h2);
      rd(2'h0, 5'h05, 3'h0, 32'h3, "removal held");
      eng(2'h1, 5'h05);
      exp_cnt[0]++;
      rd(2'h0, 5'h05, 3'h0, 32'h0, "won removal");
      evt_chk();
      // one-shot: success then loss on the same slot
      for (int k = 1; k < 3; k++) begin
         wr(2'h0, 5'h06, 3'h0, 32'h3);
         chk("one-shot flag", 1'b1, tx_one_shot_send[6]);
         eng(2'h0, 5'h06);
         eng(k[1:0], 5'h06);
         exp_cnt[k - 1]++;
         rd(2'h0, 5'h06, 3'h0, 32'h0, "one-shot end");
         evt_chk();
      end
      wr(2'h0, 5'h08, 3'h0, 32'h1);
      eng(2'h0, 5'h08);
      eng(2'h2, 5'h08);
      rd(2'h0, 5'h08, 3'h0, 32'h1, "retry kept");
      eng(2'h1, 5'h08);
      exp_cnt[0]++;
      // receive: chained pair 1 then 3, standard slot 2 with interrupt off
      cfg(5'h01, 32'h70, ident_of(1'b1, 1'b0, 29'h1ABCDEF));
      cfg(5'h03, 32'h30, ident_of(1'b1, 1'b0, 29'h1ABCDEF));
      cfg(5'h02, 32'h10, ident_of(1'b0, 1'b0, 29'h000005A5));
      for (int k = 0; k < 3; k++) begin
         frame(1'b1, 1'b0, 29'h1ABCDEF, 64'h1122);
         exp_cnt[k == 2 ? 3 : 2]++;
         evt_chk();
      end
      rd(2'h1, 5'h01, 3'h0, 32'h71, "chained ctrl");
      rd(2'h1, 5'h03, 3'h1, ident_of(1'b1, 1'b0, 29'h1ABCDEF), "ext ident");
      rd(2'h1, 5'h03, 3'h2, 32'h1122, "data low");
      frame(1'b1, 1'b0, 29'h1ABCDEE, 64'h0);
      evt_chk();
      frame(1'b0, 1'b0, 29'h000005A5, 64'h0);
      evt_chk();
      rd(2'h1, 5'h02, 3'h1, ident_of(1'b0, 1'b0, 29'h000005A5), "std ident");
      wr(2'h1, 5'h01, 3'h0, 32'h71);
      frame(1'b1, 1'b0, 29'h1ABCDEF, 64'h0);
      exp_cnt[2]++;
      evt_chk();
      // remote answers, prompt and slow, then cancel and disable
      cfg(5'h0A, 32'hB0, ident_of(1'b1, 1'b1, 29'h000CAFE));
      wr(2'h1, 5'h0A, `CMBH_F_IDENT, 32'h00CAFE0C);
      wr(2'h1, 5'h0A, `CMBH_F_DATA_LO, 32'h5EED0001);
      for (int k = 0; k < 2; k++) begin
         reply_wait <= k ? 4'h7 : 4'h0;
         frame(1'b1, 1'b1, 29'h000CAFE, 64'h0);
         repeat (12) @(posedge clk_sys);
         chk("reply ident", 32'h00CAFE0C, rd_ident);
         chk("reply data", 64'h5EED0001, rd_data);
         rd(2'h1, 5'h0A, 3'h0, 32'hB4, "answered ctrl");
         chk("remote irq", 1'b1, remote_irq);
         wr(2'h1, 5'h0A, 3'h0, 32'hB4);
         chk("remote irq", 1'b0, remote_irq);
      end
      reply_en <= 1'b0;
      frame(1'b1, 1'b1, 29'h000CAFE, 64'h0);
      chk("pending", 1'b1, ra_pending[10]);
      wr(2'h1, 5'h0A, 3'h0, 32'hB8);
      chk("cancelled", 1'b0, ra_pending[10]);
      frame(1'b1, 1'b1, 29'h000CAFE, 64'h0);
      wr(2'h1, 5'h0A, 3'h0, 32'h0);
      chk("disabled", 1'b0, ra_pending[10]);
      evt_chk();
      // random filtering on slot 0, which is searched first
      mask = xs() | xs();
      r = xs();
      code = {r[31:3], 3'h4};
      dword = xs() | xs();
      wr(2'h1, 5'h00, `CMBH_F_MASK_ID, mask);
      wr(2'h1, 5'h00, `CMBH_F_CODE_ID, code);
      wr(2'h1, 5'h00, `CMBH_F_FILT_DAT, dword);
      wr(2'h1, 5'h00, 3'h0, 32'h30);
      repeat (40) begin
         r = xs();
         id_f = (code & ~mask) | (xs() & mask);
         if (r[31:30] == 2'h0) id_f = id_f ^ (32'h1 << r[4:0]);
         dat = (dword[15:0] & ~dword[31:16]) | (r[23:8] & dword[31:16]);
         if (hits(ident_of(1'b1, 1'b0, id_f[31:3]), dat)) exp_cnt[2]++;
         frame(1'b1, 1'b0, id_f[31:3], {r, 16'h0, dat[7:0], dat[15:8]});
         evt_chk();
         wr(2'h1, 5'h00, 3'h0, 32'h31);
      end
      test_done();
   end
endmodule // tb
`default_nettype wire
